// file: atg_params.svh
// register map, field positions, reset values and counts of the angle tick generator
// assumes inclusion by bare name from every file that needs them
`ifndef ATG_PARAMS_SVH
`define ATG_PARAMS_SVH

`define ATG_ADDR_W 8
`define ATG_DATA_W 32

`define ATG_OFF_TBCR 8'h00
`define ATG_OFF_TRR 8'h04
`define ATG_OFF_TPR 8'h08
`define ATG_OFF_ANGLE 8'h0C
`define ATG_OFF_TIMEBASE 8'h10
`define ATG_OFF_STATUS 8'h14
`define ATG_OFF_WIN_OPEN 8'h18
`define ATG_OFF_WIN_CLOSE 8'h1C

// time_base_config_reg fields
`define ATG_TBCR_AM_BIT 0
`define ATG_TBCR_WIN_BIT 1
`define ATG_TBCR_PRE_LSB 8
`define ATG_TBCR_PRE_MSB 15
`define ATG_TBCR_FLT_LSB 16
`define ATG_TBCR_FLT_MSB 19
`define ATG_TBCR_RESET 32'h0000_0000

// tick_rate_register fields
`define ATG_TRR_FRAC_LSB 0
`define ATG_TRR_FRAC_MSB 7
`define ATG_TRR_INT_LSB 8
`define ATG_TRR_INT_MSB 23
`define ATG_TRR_RESET 32'h0000_0100

// tooth_program_register fields
`define ATG_TPR_TICKS_LSB 0
`define ATG_TPR_TICKS_MSB 9
`define ATG_TPR_LAST_BIT 10
`define ATG_TPR_GAP_LSB 11
`define ATG_TPR_GAP_MSB 13
`define ATG_TPR_INSERT_BIT 14
`define ATG_TPR_HOLD_BIT 15
`define ATG_TPR_RESET 32'h0000_0000

`define ATG_WIN_RESET 32'h0000_0000

// high rate step: one tick per this many system clocks
`define ATG_HIGH_RATE_DIV 8

`endif

// file: atg_pkg.sv
// types shared by the angle tick generator files
// assumes atg_params.svh for field widths
`default_nettype none
`include "atg_params.svh"

package atg_pkg;

    typedef enum logic [1:0] {
        ATG_HALT = 2'b00,
        ATG_NORMAL = 2'b01,
        ATG_HIGH = 2'b10
    } atg_state_t;

    typedef struct packed {
        logic hold;
        logic insert;
        logic [2:0] gap;
        logic last;
        logic [9:0] ticks;
    } atg_tpr_t;

    typedef struct packed {
        logic [15:0] whole;
        logic [7:0] frac;
    } atg_rate_t;

endpackage : atg_pkg
`default_nettype wire

// file: atg_tooth_filter.sv
// synchroniser and programmable glitch filter for the tooth input
// assumes tooth_i is asynchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none

module atg_tooth_filter #(
    parameter int LEN_W = 4
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic tooth_i,
    input wire logic [LEN_W-1:0] len_i,
    output logic level_o
);

    logic sync1_q;
    logic sync2_q;
    logic [LEN_W-1:0] cnt_q;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= tooth_i;
            sync2_q <= sync1_q;
        end
    end

    // a new level must stand len_i + 1 cycles before it is passed on
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            level_o <= 1'b0;
        end else if (sync2_q == level_o) begin
            cnt_q <= '0;
        end else if (cnt_q >= len_i) begin
            cnt_q <= '0;
            level_o <= sync2_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule : atg_tooth_filter
`default_nettype wire

// file: atg_angle_tick.sv
// angle counter with interpolated ticks between wheel teeth
// assumes a plain register port on core_clk_i and an asynchronous tooth pin
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "atg_params.svh"

module atg_angle_tick
    import atg_pkg::*;
#(
    parameter int ANG_W = 24,
    parameter int TB_W = 24
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic tooth_i,
    input wire logic [`ATG_ADDR_W-1:0] addr_i,
    input wire logic [`ATG_DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`ATG_DATA_W-1:0] rd_data_o,
    output logic [ANG_W-1:0] shared_timebase_bus_o,
    output logic [TB_W-1:0] time_base_counter_o,
    output logic external_counter_clock_in_o,
    output logic [1:0] mode_o
);

    localparam int FLT_W = `ATG_TBCR_FLT_MSB - `ATG_TBCR_FLT_LSB + 1;
    localparam int PRE_W = `ATG_TBCR_PRE_MSB - `ATG_TBCR_PRE_LSB + 1;
    localparam int HR_W = $clog2(`ATG_HIGH_RATE_DIV);
    localparam logic [HR_W-1:0] HR_LAST = HR_W'(`ATG_HIGH_RATE_DIV - 1);

    logic [`ATG_DATA_W-1:0] time_base_config_reg;
    atg_rate_t tick_rate_register;
    atg_tpr_t tooth_program_register;
    logic [TB_W-1:0] win_open_q;
    logic [TB_W-1:0] win_close_q;
    logic [`ATG_DATA_W-1:0] rd_data_q;

    logic [TB_W-1:0] time_base_q;
    logic [PRE_W-1:0] pre_cnt_q;
    logic tb_tick;

    logic flt_level;
    logic flt_prev_q;
    logic ext_clk_q;

    atg_state_t state_q;
    atg_state_t state_d;
    logic [ANG_W-1:0] angle_counter;
    logic [ANG_W-1:0] angle_d;
    logic [9:0] tick_cnt_q;
    logic [9:0] tick_cnt_d;
    logic hold_act_q;
    logic hold_act_d;
    logic hold_prev_q;

    logic [15:0] per_cnt_q;
    logic [7:0] frac_acc_q;
    logic [8:0] frac_sum;
    logic per_done;
    logic per_rst;
    logic [HR_W-1:0] hr_cnt_q;
    logic hr_step;

    logic angle_mode_enable;
    logic window_ok;
    logic phys_tooth;
    logic tooth_insert_bit;
    logic insert_pulse_q;
    logic tooth_evt;
    logic gap_dec;
    logic last_clr;
    logic wr_tpr;

    assign angle_mode_enable = time_base_config_reg[`ATG_TBCR_AM_BIT];
    assign tooth_insert_bit = tooth_program_register.insert;
    assign wr_tpr = wr_i && (addr_i == `ATG_OFF_TPR);

    // time base counter, prescaled from the system clock
    assign tb_tick = (pre_cnt_q == time_base_config_reg[`ATG_TBCR_PRE_MSB:`ATG_TBCR_PRE_LSB]);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pre_cnt_q <= '0;
            time_base_q <= '0;
        end else if (tb_tick) begin
            pre_cnt_q <= '0;
            time_base_q <= time_base_q + 1'b1;
        end else begin
            pre_cnt_q <= pre_cnt_q + 1'b1;
        end
    end

    atg_tooth_filter #(
        .LEN_W(FLT_W)
    ) u_filter (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .tooth_i(tooth_i),
        .len_i(time_base_config_reg[`ATG_TBCR_FLT_MSB:`ATG_TBCR_FLT_LSB]),
        .level_o(flt_level)
    );

    // match window: open <= time base < close
    assign window_ok = !time_base_config_reg[`ATG_TBCR_WIN_BIT] ||
                       ((time_base_q >= win_open_q) && (time_base_q < win_close_q));

    // rising edge of filtered tooth, only in angle mode and inside the window
    assign phys_tooth = angle_mode_enable && flt_level && !flt_prev_q && window_ok;

    // inserted tooth is dropped while catching up at high rate
    assign tooth_evt = phys_tooth || (insert_pulse_q && (state_q != ATG_HIGH));

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flt_prev_q <= 1'b0;
            ext_clk_q <= 1'b0;
        end else begin
            flt_prev_q <= flt_level;
            ext_clk_q <= angle_mode_enable && flt_level;
        end
    end

    // tick period: whole part in time base ticks, plus one when the fraction carries
    // the carry stretches the period that overflows, so whole periods sum exactly
    assign frac_sum = {1'b0, frac_acc_q} + {1'b0, tick_rate_register.frac};
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            per_cnt_q <= '0;
            frac_acc_q <= '0;
        end else if (per_rst) begin
            per_cnt_q <= '0;
            frac_acc_q <= '0;
        end else if (state_q == ATG_NORMAL && tb_tick) begin
            if (per_done) begin
                per_cnt_q <= '0;
                frac_acc_q <= frac_sum[7:0];
            end else begin
                per_cnt_q <= per_cnt_q + 1'b1;
            end
        end
    end

    always_comb begin
        logic [16:0] target;
        target = {1'b0, tick_rate_register.whole} + {16'h0000, frac_sum[8]};
        if (target == 17'h00000) begin
            target = 17'h00001;
        end
        per_done = (state_q == ATG_NORMAL) && tb_tick &&
                   ({1'b0, per_cnt_q} + 17'h00001 >= target);
    end

    // high rate divider, one step every eighth system clock
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hr_cnt_q <= '0;
        end else if (state_q != ATG_HIGH) begin
            hr_cnt_q <= '0;
        end else if (hr_cnt_q == HR_LAST) begin
            hr_cnt_q <= '0;
        end else begin
            hr_cnt_q <= hr_cnt_q + 1'b1;
        end
    end

    assign hr_step = (state_q == ATG_HIGH) && (hr_cnt_q == HR_LAST);

    // angle engine
    always_comb begin
        state_d = state_q;
        angle_d = angle_counter;
        tick_cnt_d = tick_cnt_q;
        hold_act_d = hold_act_q;
        gap_dec = 1'b0;
        last_clr = 1'b0;
        per_rst = 1'b0;
        if (hold_act_q) begin
            // frozen for one tooth; the tooth itself is not counted
            if (tooth_evt) begin
                hold_act_d = 1'b0;
                state_d = ATG_NORMAL;
                tick_cnt_d = '0;
                per_rst = 1'b1;
            end else if (!tooth_program_register.hold) begin
                hold_act_d = 1'b0;
            end
        end else if (tooth_program_register.hold && !hold_prev_q) begin
            hold_act_d = 1'b1;
        end else begin
            case (state_q)
                ATG_HALT: begin
                    if (tooth_evt) begin
                        if (tooth_program_register.last) begin
                            angle_d = '0;
                            last_clr = 1'b1;
                        end else begin
                            angle_d = angle_counter + 1'b1;
                        end
                        tick_cnt_d = '0;
                        state_d = ATG_NORMAL;
                        per_rst = 1'b1;
                    end
                end
                ATG_NORMAL: begin
                    if (tooth_evt && tick_cnt_q < tooth_program_register.ticks) begin
                        state_d = ATG_HIGH;
                    end else if (tooth_evt) begin
                        if (tooth_program_register.last) begin
                            angle_d = '0;
                            last_clr = 1'b1;
                        end else begin
                            angle_d = angle_counter + 1'b1;
                        end
                        tick_cnt_d = '0;
                        per_rst = 1'b1;
                    end else if (per_done) begin
                        if (tick_cnt_q < tooth_program_register.ticks) begin
                            angle_d = angle_counter + 1'b1;
                            tick_cnt_d = tick_cnt_q + 1'b1;
                        end else if (tooth_program_register.gap != 3'h0) begin
                            gap_dec = 1'b1;
                            angle_d = angle_counter + 1'b1;
                            tick_cnt_d = '0;
                        end else begin
                            // the period after the last tick ran out: wait for the tooth
                            state_d = ATG_HALT;
                        end
                    end
                end
                ATG_HIGH: begin
                    if (hr_step) begin
                        if (tick_cnt_q < tooth_program_register.ticks) begin
                            angle_d = angle_counter + 1'b1;
                            tick_cnt_d = tick_cnt_q + 1'b1;
                        end else begin
                            if (tooth_program_register.last) begin
                                angle_d = '0;
                                last_clr = 1'b1;
                            end else begin
                                angle_d = angle_counter + 1'b1;
                            end
                            tick_cnt_d = '0;
                            state_d = ATG_NORMAL;
                            per_rst = 1'b1;
                        end
                    end
                end
                default: begin
                    state_d = ATG_HALT;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ATG_HALT;
            angle_counter <= '0;
            tick_cnt_q <= '0;
            hold_act_q <= 1'b0;
            hold_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            angle_counter <= angle_d;
            tick_cnt_q <= tick_cnt_d;
            hold_act_q <= hold_act_d;
            hold_prev_q <= tooth_program_register.hold;
        end
    end

    // configuration registers written by software
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            time_base_config_reg <= `ATG_TBCR_RESET;
            tick_rate_register <= atg_rate_t'(`ATG_TRR_RESET);
            win_open_q <= TB_W'(`ATG_WIN_RESET);
            win_close_q <= TB_W'(`ATG_WIN_RESET);
        end else if (wr_i) begin
            if (addr_i == `ATG_OFF_TBCR) begin
                time_base_config_reg <= wr_data_i;
            end else if (addr_i == `ATG_OFF_TRR) begin
                tick_rate_register <= wr_data_i[`ATG_TRR_INT_MSB:`ATG_TRR_FRAC_LSB];
            end else if (addr_i == `ATG_OFF_WIN_OPEN) begin
                win_open_q <= wr_data_i[TB_W-1:0];
            end else if (addr_i == `ATG_OFF_WIN_CLOSE) begin
                win_close_q <= wr_data_i[TB_W-1:0];
            end
        end
    end

    // tooth program register: a software write wins over the hardware update
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tooth_program_register <= atg_tpr_t'(`ATG_TPR_RESET);
            insert_pulse_q <= 1'b0;
        end else if (wr_tpr) begin
            tooth_program_register.ticks <= wr_data_i[`ATG_TPR_TICKS_MSB:`ATG_TPR_TICKS_LSB];
            tooth_program_register.last <= wr_data_i[`ATG_TPR_LAST_BIT];
            tooth_program_register.gap <= wr_data_i[`ATG_TPR_GAP_MSB:`ATG_TPR_GAP_LSB];
            tooth_program_register.hold <= wr_data_i[`ATG_TPR_HOLD_BIT];
            tooth_program_register.insert <= 1'b0;
            insert_pulse_q <= wr_data_i[`ATG_TPR_INSERT_BIT];
        end else begin
            insert_pulse_q <= 1'b0;
            if (last_clr) begin
                tooth_program_register.last <= 1'b0;
            end
            if (gap_dec) begin
                tooth_program_register.gap <= tooth_program_register.gap - 1'b1;
            end
        end
    end

    // read port: data in the cycle after the strobe
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_q <= '0;
        end else if (rd_i) begin
            if (addr_i == `ATG_OFF_TBCR) begin
                rd_data_q <= time_base_config_reg;
            end else if (addr_i == `ATG_OFF_TRR) begin
                rd_data_q <= {8'h00, tick_rate_register};
            end else if (addr_i == `ATG_OFF_TPR) begin
                rd_data_q <= {16'h0000, tooth_program_register.hold, tooth_insert_bit,
                              tooth_program_register.gap, tooth_program_register.last,
                              tooth_program_register.ticks};
            end else if (addr_i == `ATG_OFF_ANGLE) begin
                rd_data_q <= `ATG_DATA_W'(angle_counter);
            end else if (addr_i == `ATG_OFF_TIMEBASE) begin
                rd_data_q <= `ATG_DATA_W'(time_base_q);
            end else if (addr_i == `ATG_OFF_STATUS) begin
                rd_data_q <= {19'h00000, tick_cnt_q, hold_act_q, state_q};
            end else if (addr_i == `ATG_OFF_WIN_OPEN) begin
                rd_data_q <= `ATG_DATA_W'(win_open_q);
            end else if (addr_i == `ATG_OFF_WIN_CLOSE) begin
                rd_data_q <= `ATG_DATA_W'(win_close_q);
            end else begin
                rd_data_q <= '0;
            end
        end else begin
            rd_data_q <= '0;
        end
    end

    assign rd_data_o = rd_data_q;
    assign shared_timebase_bus_o = angle_counter;
    assign time_base_counter_o = time_base_q;
    assign external_counter_clock_in_o = ext_clk_q;
    assign mode_o = state_q;

endmodule : atg_angle_tick
`default_nettype wire

// file: atg_angle_tick_props.sv
// port checker for the angle tick generator
// assumes bind onto atg_angle_tick; one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "atg_params.svh"

module atg_angle_tick_props
    import atg_pkg::*;
#(
    parameter int ANG_W = 24,
    parameter int TB_W = 24
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic tooth_i,
    input wire logic [`ATG_ADDR_W-1:0] addr_i,
    input wire logic [`ATG_DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [`ATG_DATA_W-1:0] rd_data_o,
    input wire logic [ANG_W-1:0] shared_timebase_bus_o,
    input wire logic [TB_W-1:0] time_base_counter_o,
    input wire logic external_counter_clock_in_o,
    input wire logic [1:0] mode_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    logic [ANG_W-1:0] ang_q;
    logic [3:0] since_q;
    logic hi_q;

    // saturates so long idle gaps never wrap into a false spacing
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ang_q <= '0;
            since_q <= 4'h0;
            hi_q <= 1'b0;
        end else begin
            ang_q <= shared_timebase_bus_o;
            if (shared_timebase_bus_o != ang_q) begin
                since_q <= 4'h0;
                hi_q <= (mode_o == ATG_HIGH);
            end else if (since_q != 4'hF) begin
                since_q <= since_q + 4'h1;
            end
        end
    end

    reset_state_a: assert property ($fell(reset_i) |->
        mode_o == ATG_HALT && shared_timebase_bus_o == '0) else $error("bad state after reset");
    halt_still_a: assert property ($past(mode_o) == ATG_HALT && mode_o == ATG_HALT
        |-> $stable(shared_timebase_bus_o)) else $error("angle moved in halt");
    normal_halt_a: assert property ($past(mode_o) == ATG_NORMAL && mode_o == ATG_HALT
        |-> $stable(shared_timebase_bus_o)) else $error("angle moved entering halt");
    halt_high_a: assert property ($past(mode_o) == ATG_HALT |-> mode_o != ATG_HIGH)
        else $error("halt went straight to high rate");
    high_space_a: assert property ($changed(shared_timebase_bus_o) && hi_q
        && mode_o == ATG_HIGH |-> since_q == 4'h7) else $error("high rate step not 8 clocks");
    angle_step_a: assert property ($changed(shared_timebase_bus_o) |->
        shared_timebase_bus_o - $past(shared_timebase_bus_o) == ANG_W'(1)
        || shared_timebase_bus_o == '0) else $error("angle skipped a value");
    rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == '0)
        else $error("read data outside its cycle");
    angle_read_a: assert property (rd_i && addr_i == `ATG_OFF_ANGLE ##1
        $stable(shared_timebase_bus_o) |-> rd_data_o == `ATG_DATA_W'(shared_timebase_bus_o))
        else $error("angle read mismatch");
    base_step_a: assert property ($changed(time_base_counter_o) |->
        time_base_counter_o - $past(time_base_counter_o) == TB_W'(1))
        else $error("time base skipped a value");

    cover property (mode_o == ATG_HIGH);
    cover property ($past(mode_o) == ATG_NORMAL && mode_o == ATG_HALT);
    cover property ($past(shared_timebase_bus_o) != '0 && shared_timebase_bus_o == '0);
endmodule : atg_angle_tick_props
`default_nettype wire

// file: atg_wheel_model.sv
// toothed wheel stand-in: one tooth pulse per fire request
// assumes fire_i and width_i change just after clock edges
`timescale 1ns/100ps
`default_nettype none

module atg_wheel_model (
    input wire logic core_clk_i,
    input wire logic fire_i,
    input wire logic [7:0] width_i,
    output logic tooth_o
);
    // edges land off the clock so the pin stays truly asynchronous
    initial begin
        tooth_o = 1'b0;
        forever begin
            @(posedge core_clk_i);
            if (fire_i) begin
                #1.3 tooth_o = 1'b1;
                repeat (width_i) @(posedge core_clk_i);
                #1.3 tooth_o = 1'b0;
            end
        end
    end
endmodule : atg_wheel_model
`default_nettype wire

// file: atg_angle_tick_tb.sv
// self-checking bench for the angle tick generator
// assumes the wheel model and the port checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "atg_params.svh"

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED %0t: got %0h want %0h", $time, a, b); end end

module atg_angle_tick_tb
    import atg_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tooth;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fire = 1'b0;
    logic [7:0] wid = 8'h0C;
    logic [31:0] rdat;
    logic [23:0] ang;
    logic [1:0] mode;
    logic ext;
    logic ext_p = 1'b0;
    int ext_n = 0;
    logic [31:0] exp_q[$];
    logic [31:0] e_w;
    logic pend = 1'b0;
    logic [23:0] ea = 24'h000000;
    int bad_count = 0;
    int comparisons = 0;
    int t;
    int n;
    logic seen;
    logic [7:0] offs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [31:0] rsts[8] = '{`ATG_TBCR_RESET, `ATG_TRR_RESET, `ATG_TPR_RESET,
        32'h0000_0000, 32'h0000_0000, `ATG_WIN_RESET, `ATG_WIN_RESET, 32'h0000_0000};

    always #2.5 clk = ~clk;

    atg_angle_tick DUT (.core_clk_i(clk), .reset_i(rst), .tooth_i(tooth), .addr_i(addr),
        .wr_data_i(wdat), .wr_i(wr), .rd_i(rd), .rd_data_o(rdat),
        .shared_timebase_bus_o(ang), .time_base_counter_o(),
        .external_counter_clock_in_o(ext), .mode_o(mode));
    atg_wheel_model u_wheel (.core_clk_i(clk), .fire_i(fire), .width_i(wid),
        .tooth_o(tooth));

    // read data stands one cycle after the strobe; pend spans that gap
    always @(negedge clk) begin
        if (pend) begin
            e_w = exp_q.pop_front();
            `CHK(rdat, e_w)
        end
        pend = rd;
        ext_n += int'(ext && !ext_p);
        ext_p = ext;
    end

    task automatic end_of_test();
        $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rreg

    task automatic spin(input logic [7:0] w);
        @(posedge clk);
        wid <= w;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask : spin

    task automatic wait_halt();
        repeat (60) @(posedge clk);
        n = 0;
        while (mode !== ATG_HALT && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) begin
            bad_count++;
            $display("CHECK FAILED %0t: no halt", $time);
            end_of_test();
        end
    endtask : wait_halt

    task automatic chk_ang();
        rreg(`ATG_OFF_ANGLE, {8'h00, ea});
    endtask : chk_ang

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        void'($urandom(83414));
        for (int i = 0; i < 8; i++) rreg(offs[i], rsts[i]);
        wreg(`ATG_OFF_ANGLE, 32'h0000_00FF);
        chk_ang();
        wreg(`ATG_OFF_TBCR, 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            t = 1 + ($urandom % 6);
            wreg(`ATG_OFF_TRR, {16'h0000, 8'(1 + $urandom % 4), 8'h00});
            wreg(`ATG_OFF_TPR, 32'(t));
            spin(8'h0C);
            wait_halt();
            ea += 24'(t + 1);
            chk_ang();
        end
        // half-step fraction: four periods of 2.5 land on exactly 10 clocks
        wreg(`ATG_OFF_TRR, 32'h0000_0280);
        wreg(`ATG_OFF_TPR, 32'h0000_0003);
        spin(8'h0C);
        n = 0;
        while (ang === ea && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            bad_count++;
            $display("CHECK FAILED %0t: no tooth", $time);
            end_of_test();
        end
        n = 0;
        while (mode !== ATG_HALT && n < 200) begin
            @(posedge clk);
            n++;
        end
        `CHK(n, 10)
        ea += 24'h4;
        wreg(`ATG_OFF_TRR, 32'h0000_0800);
        wreg(`ATG_OFF_TPR, 32'h0000_0014);
        spin(8'h0C);
        repeat (60) @(posedge clk);
        spin(8'h0C);
        seen = 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            seen |= (mode === ATG_HIGH);
        end
        `CHK(seen, 1'b1)
        wait_halt();
        ea += 24'd42;
        chk_ang();
        wreg(`ATG_OFF_TRR, 32'h0000_0100);
        wreg(`ATG_OFF_TPR, 32'h0000_0803);
        spin(8'h0C);
        wait_halt();
        ea += 24'h8;
        chk_ang();
        rreg(`ATG_OFF_TPR, 32'h0000_0003);
        wreg(`ATG_OFF_TPR, 32'h0000_0403);
        spin(8'h0C);
        wait_halt();
        ea = 24'h3;
        chk_ang();
        rreg(`ATG_OFF_TPR, 32'h0000_0003);
        wreg(`ATG_OFF_TPR, 32'h0000_4003);
        wait_halt();
        ea += 24'h4;
        chk_ang();
        rreg(`ATG_OFF_TPR, 32'h0000_0003);
        wreg(`ATG_OFF_TBCR, 32'h0000_0003);
        spin(8'h0C);
        wait_halt();
        chk_ang();
        wreg(`ATG_OFF_WIN_CLOSE, 32'h00FF_FFFF);
        spin(8'h0C);
        wait_halt();
        ea += 24'h4;
        chk_ang();
        wreg(`ATG_OFF_TBCR, 32'h0000_0000);
        t = ext_n;
        spin(8'h0C);
        wait_halt();
        chk_ang();
        `CHK(ext_n - t, 0)
        wreg(`ATG_OFF_TBCR, 32'h000F_0001);
        spin(8'h06);
        wait_halt();
        chk_ang();
        spin(8'h28);
        wait_halt();
        ea += 24'h4;
        chk_ang();
        `CHK(ext_n - t, 1)
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule : atg_angle_tick_tb

bind atg_angle_tick atg_angle_tick_props #(.ANG_W(ANG_W), .TB_W(TB_W)) u_props (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .tooth_i(tooth_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .shared_timebase_bus_o(shared_timebase_bus_o), .time_base_counter_o(time_base_counter_o),
    .external_counter_clock_in_o(external_counter_clock_in_o), .mode_o(mode_o));
`default_nettype wire
